// *** center_aligned_output_map.svh ***
// register offsets, field positions and reset values for the center-aligned pwm channel
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH
`define CTRL_OFFSET        12'h000
`define MOD_HIGH_OFFSET    12'h004
`define MOD_LOW_OFFSET     12'h008
`define CMP_HIGH_OFFSET    12'h00c
`define CMP_LOW_OFFSET     12'h010
`define STATUS_OFFSET      12'h014
`define COUNT_OFFSET       12'h018
`define CTRL_CENTER_BIT    0
`define CTRL_POLARITY_BIT  1
`define CTRL_ENABLE_BIT    2
`define CTRL_RESET         3'h0
`define MOD_RESET          16'h0000
`define CMP_RESET          16'h0000
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// *** center_aligned_output_pkg.sv ***
// types shared by the center-aligned pwm channel
package pwm_pkg;
  typedef enum logic {
    dir_up,
    dir_down
  } dir_type;
  typedef logic [15:0] word16_type;
endpackage

// *** center_aligned_output_channel.sv ***
// center-aligned pwm channel with an axi4-lite register slave
`timescale 1ns/10ps
`include "center_aligned_output_map.svh"
module center_pwm_channel
(
  input  wire logic                 clock_in,         // 40 mhz system clock
  input  wire logic                 resetn_in,        // synchronous reset, active low
  input  wire logic                 clock_enable_in,  // freezes all state when low
  input  wire logic [11:0]          s_axi_awaddr,     // write address
  input  wire logic                 s_axi_awvalid,    // write address valid
  output logic                      s_axi_awready,    // write address ready
  input  wire logic [31:0]          s_axi_wdata,      // write data
  input  wire logic [3:0]           s_axi_wstrb,      // write byte strobes
  input  wire logic                 s_axi_wvalid,     // write data valid
  output logic                      s_axi_wready,     // write data ready
  output logic [1:0]                s_axi_bresp,      // write response
  output logic                      s_axi_bvalid,     // write response valid
  input  wire logic                 s_axi_bready,     // write response ready
  input  wire logic [11:0]          s_axi_araddr,     // read address
  input  wire logic                 s_axi_arvalid,    // read address valid
  output logic                      s_axi_arready,    // read address ready
  output logic [31:0]               s_axi_rdata,      // read data
  output logic [1:0]                s_axi_rresp,      // read response
  output logic                      s_axi_rvalid,     // read data valid
  input  wire logic                 s_axi_rready,     // read data ready
  output pwm_pkg::word16_type       counter_out,      // live counter value
  output logic                      center_aligned_output_out  // pwm pin
);
  import pwm_pkg::*;

  // register state
  logic       center_mode_select, next_center_mode_select;
  logic       polarity_select_a, next_polarity_select_a;
  logic       run_enable, next_run_enable;
  logic [7:0] mod_high_buf, next_mod_high_buf, mod_low_buf, next_mod_low_buf;
  logic [7:0] cmp_high_buf, next_cmp_high_buf, cmp_low_buf, next_cmp_low_buf;
  logic [1:0] mod_written, next_mod_written, cmp_written, next_cmp_written;
  word16_type modulus, next_modulus;
  word16_type compare, next_compare;
  // counter state
  word16_type count, next_count;
  dir_type    dir, next_dir;
  logic       pwm, next_pwm;
  // bus state
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic        bvalid, next_bvalid, rvalid, next_rvalid;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, rdata, next_rdata;
  logic [3:0]  w_strb, next_w_strb;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;

  logic        do_write, boundary, cmp_negative, cmp_match, mod_match;

  // write goes through once both address and data are held and no response waits
  assign do_write      = aw_held && w_held && !bvalid;
  assign s_axi_awready = !aw_held && !bvalid && clock_enable_in;  // masked while frozen: no beat lost
  assign s_axi_wready  = !w_held && !bvalid && clock_enable_in;
  assign s_axi_arready = !rvalid && clock_enable_in;
  assign s_axi_bvalid  = bvalid && clock_enable_in;               // a frozen answer is never taken twice
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid && clock_enable_in;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;
  assign counter_out   = count;
  assign center_aligned_output_out = pwm;

  // period boundary: count at zero, where the next cycle begins
  assign boundary     = (count == 16'h0000);
  assign cmp_negative = compare[15];
  assign cmp_match    = (count == compare) && (compare != 16'h0000) && !cmp_negative;
  assign mod_match    = (count == modulus) && (modulus != 16'h0000);

  // bus and register next-state
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    next_center_mode_select = center_mode_select;
    next_polarity_select_a  = polarity_select_a;
    next_run_enable  = run_enable;
    next_mod_high_buf = mod_high_buf;
    next_mod_low_buf  = mod_low_buf;
    next_cmp_high_buf = cmp_high_buf;
    next_cmp_low_buf  = cmp_low_buf;
    next_mod_written  = mod_written;
    next_cmp_written  = cmp_written;
    next_modulus = modulus;
    next_compare = compare;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `RESP_OKAY;
      // byte writes only reach buffers, never the live compare words
      if (aw_addr == `CTRL_OFFSET) begin
        if (w_strb[0]) begin
          next_center_mode_select = w_data[`CTRL_CENTER_BIT];
          next_polarity_select_a  = w_data[`CTRL_POLARITY_BIT];
          next_run_enable         = w_data[`CTRL_ENABLE_BIT];
        end
      end else if (aw_addr == `MOD_HIGH_OFFSET) begin
        if (w_strb[0]) begin
          next_mod_high_buf = w_data[7:0];
          next_mod_written  = mod_written | 2'h2;
        end
      end else if (aw_addr == `MOD_LOW_OFFSET) begin
        if (w_strb[0]) begin
          next_mod_low_buf = w_data[7:0];
          next_mod_written = mod_written | 2'h1;
        end
      end else if (aw_addr == `CMP_HIGH_OFFSET) begin
        if (w_strb[0]) begin
          next_cmp_high_buf = w_data[7:0];
          next_cmp_written  = cmp_written | 2'h2;
        end
      end else if (aw_addr == `CMP_LOW_OFFSET) begin
        if (w_strb[0]) begin
          next_cmp_low_buf = w_data[7:0];
          next_cmp_written = cmp_written | 2'h1;
        end
      end else if (aw_addr == `STATUS_OFFSET || aw_addr == `COUNT_OFFSET) begin
        next_bresp = `RESP_OKAY;
      end else begin
        next_bresp = `RESP_SLVERR;
      end
    end
    // coherent transfer at the period boundary; a byte landing this cycle waits for the next
    if (boundary && (mod_written == 2'h3) && !(do_write && (aw_addr == `MOD_HIGH_OFFSET
        || aw_addr == `MOD_LOW_OFFSET))) begin
      next_modulus     = {mod_high_buf, mod_low_buf};
      next_mod_written = 2'h0;
    end
    if (boundary && (cmp_written == 2'h3) && !(do_write && (aw_addr == `CMP_HIGH_OFFSET
        || aw_addr == `CMP_LOW_OFFSET))) begin
      next_compare     = {cmp_high_buf, cmp_low_buf};
      next_cmp_written = 2'h0;
    end
    // read path; unmapped answers slverr with zero data
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (s_axi_araddr == `CTRL_OFFSET) begin
        next_rdata = {29'h0, run_enable, polarity_select_a, center_mode_select};
      end else if (s_axi_araddr == `MOD_HIGH_OFFSET) begin
        next_rdata = {24'h0, mod_high_buf};
      end else if (s_axi_araddr == `MOD_LOW_OFFSET) begin
        next_rdata = {24'h0, mod_low_buf};
      end else if (s_axi_araddr == `CMP_HIGH_OFFSET) begin
        next_rdata = {24'h0, cmp_high_buf};
      end else if (s_axi_araddr == `CMP_LOW_OFFSET) begin
        next_rdata = {24'h0, cmp_low_buf};
      end else if (s_axi_araddr == `STATUS_OFFSET) begin
        next_rdata = {26'h0, cmp_written, mod_written, pwm, dir == dir_down};
      end else if (s_axi_araddr == `COUNT_OFFSET) begin
        next_rdata = {16'h0, count};
      end else begin
        next_rresp = `RESP_SLVERR;
      end
    end
  end

  // counter and pwm next-state
  always_comb begin
    next_count = count;
    next_dir   = dir;
    next_pwm   = pwm;
    if (run_enable) begin
      if (center_mode_select) begin
        // up/down counting, turn down only at a nonzero modulus match, back up at count one or zero
        if (dir == dir_up) begin
          if (mod_match) begin
            next_dir   = dir_down;
            next_count = count - 16'h0001;
          end else begin
            next_count = count + 16'h0001;
          end
        end else begin
          if (count == 16'h0001 || count == 16'h0000) begin
            next_dir = dir_up;
          end
          next_count = (count == 16'h0000) ? 16'h0001 : count - 16'h0001;
        end
        // compare sets the width; polarity picks the sense
        if (compare == 16'h0000 || cmp_negative) begin
          next_pwm = polarity_select_a;
        end else if (compare > modulus && modulus != 16'h0000) begin
          next_pwm = !polarity_select_a;
        end else if (cmp_match && dir == dir_up) begin
          next_pwm = polarity_select_a;
        end else if (cmp_match && dir == dir_down) begin
          next_pwm = !polarity_select_a;
        end
      end else begin
        // edge mode: zero modulus runs free and wraps
        next_dir = dir_up;
        if (modulus != 16'h0000 && count == modulus) begin
          next_count = 16'h0000;
        end else begin
          next_count = count + 16'h0001;
        end
      end
    end
  end

  // register every group; clock enable freezes everything
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= `RESP_OKAY;
      rdata   <= 32'h0000_0000;
      {run_enable, polarity_select_a, center_mode_select} <= `CTRL_RESET;
      mod_high_buf <= 8'h00;
      mod_low_buf  <= 8'h00;
      cmp_high_buf <= 8'h00;
      cmp_low_buf  <= 8'h00;
      mod_written  <= 2'h0;
      cmp_written  <= 2'h0;
      modulus <= `MOD_RESET;
      compare <= `CMP_RESET;
      count   <= 16'h0000;
      dir     <= dir_up;
      pwm     <= 1'b0;
    end else if (clock_enable_in) begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      center_mode_select <= next_center_mode_select;
      polarity_select_a  <= next_polarity_select_a;
      run_enable   <= next_run_enable;
      mod_high_buf <= next_mod_high_buf;
      mod_low_buf  <= next_mod_low_buf;
      cmp_high_buf <= next_cmp_high_buf;
      cmp_low_buf  <= next_cmp_low_buf;
      mod_written  <= next_mod_written;
      cmp_written  <= next_cmp_written;
      modulus <= next_modulus;
      compare <= next_compare;
      count   <= next_count;
      dir     <= next_dir;
      pwm     <= next_pwm;
    end
  end

  // assertions
  sequence s_up_match;
    clock_enable_in && run_enable && center_mode_select && dir == dir_up && mod_match;
  endsequence

  a_turn_at_mod: assert property (@(posedge clock_in) disable iff (!resetn_in)
    s_up_match |=> dir == dir_down && count == $past(modulus) - 16'h0001)
    else $error("counter did not turn at modulus");
  a_no_turn_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (clock_enable_in && run_enable && center_mode_select && dir == dir_up && modulus == 16'h0000)
      |=> dir == dir_up)
    else $error("counter turned at zero modulus");
  a_down_to_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (clock_enable_in && run_enable && center_mode_select && dir == dir_down && count > 16'h0001)
      |=> count == $past(count) - 16'h0001)
    else $error("down count step wrong");
  a_free_wrap: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (clock_enable_in && run_enable && !center_mode_select && modulus == 16'h0000 && count == 16'hffff)
      |=> count == 16'h0000)
    else $error("free run did not wrap");
  a_zero_duty: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (clock_enable_in && run_enable && center_mode_select && (compare == 16'h0000 || compare[15]))
      |=> pwm == $past(polarity_select_a))
    else $error("zero duty not held");
  a_full_duty: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (clock_enable_in && run_enable && center_mode_select && !compare[15] && compare > modulus
      && modulus != 16'h0000) |=> pwm == !$past(polarity_select_a))
    else $error("full duty not held");
  a_up_match: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (clock_enable_in && run_enable && center_mode_select && cmp_match && dir == dir_up
      && !(compare > modulus)) |=> pwm == $past(polarity_select_a))
    else $error("up match output wrong");
  a_down_match: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (clock_enable_in && run_enable && center_mode_select && cmp_match && dir == dir_down
      && !(compare > modulus)) |=> pwm == !$past(polarity_select_a))
    else $error("down match output wrong");
  a_buffer_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (clock_enable_in && !boundary) |=> modulus == $past(modulus) && compare == $past(compare))
    else $error("live value changed off boundary");
endmodule

// *** pwm_load.sv ***
// external load model that integrates the pwm pin over a measuring window
`timescale 1ns/10ps
module pwm_load (
  input  wire logic        clock_in,   // system clock
  input  wire logic        pin_in,     // pwm pin from the channel
  input  wire logic        window_in,  // high while the load integrates
  output logic [16:0]      high_out    // cycles seen high in the last window
);
  logic window_q;
  // restart on window open, keep the total after it closes so the bench can read late
  always @(posedge clock_in) begin
    window_q <= window_in;
    if (window_in && !window_q) begin
      high_out <= {16'h0000, pin_in};
    end else if (window_in) begin
      high_out <= high_out + {16'h0000, pin_in};
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench for the center-aligned pwm channel
`timescale 1ns/10ps
`include "center_aligned_output_map.svh"
module testbench;
  import pwm_pkg::*;
  localparam int unsigned ceiling = 90000;
  logic        clock_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        clock_enable_in = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        window = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pwm;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  word16_type  counter;
  logic [16:0] high;
  int          fails = 0;
  int          check_count = 0;
  int          cycles = 0;

  center_pwm_channel DUT (.clock_in(clock_in), .resetn_in(resetn_in), .clock_enable_in(clock_enable_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .counter_out(counter), .center_aligned_output_out(pwm));
  pwm_load load (.clock_in(clock_in), .pin_in(pwm), .window_in(window), .high_out(high));

  // 40 mhz clock
  always #12.5 clock_in = ~clock_in;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, sized for the long free-run wrap near the end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == ceiling) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic compare_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic compare_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // only the low byte lane counts, so the upper lanes carry noise
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
    logic aw_done;
    logic w_done;
    @(posedge clock_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'($urandom), d};
    wstrb <= {3'($urandom), 1'b1};
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge clock_in);
      if (awready === 1'b1 && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock_in); while (bvalid !== 1'b1);
    compare_resp("write response", `RESP_OKAY, bresp);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock_in); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // control last, so the new buffers settle before the mode changes
  task automatic prog(input word16_type m, input word16_type c, input logic [2:0] ctrl);
    axi_write(`MOD_HIGH_OFFSET, m[15:8]);
    axi_write(`MOD_LOW_OFFSET, m[7:0]);
    axi_write(`CMP_HIGH_OFFSET, c[15:8]);
    axi_write(`CMP_LOW_OFFSET, c[7:0]);
    axi_write(`CTRL_OFFSET, {5'h00, ctrl});
  endtask

  // expected cycles high in one period of 2*m
  function automatic logic [16:0] expect_high(input word16_type m, input word16_type c, input logic pol);
    logic [16:0] full;
    full = {m, 1'b0};
    if (c == 16'h0000 || c[15]) return pol ? full : 17'h00000;
    if (c > m) return pol ? 17'h00000 : full;
    return pol ? full - {c, 1'b0} : {c, 1'b0};
  endfunction

  // wait out the longest old period, since new buffers only load at its end, then settle two periods;
  // then time one period from zero and let the load integrate it
  task automatic measure(input word16_type m, input logic [16:0] exp);
    repeat (4 * m + 224) @(posedge clock_in);
    do @(posedge clock_in); while (counter !== 16'h0000);
    window <= 1'b1;
    repeat (m) @(posedge clock_in);
    compare_word("turn count", {16'h0000, m}, {16'h0000, counter});
    repeat (m) @(posedge clock_in);
    compare_word("period end", 32'h0000_0000, {16'h0000, counter});
    window <= 1'b0;
    repeat (2) @(posedge clock_in);
    compare_word("high cycles", {15'h0000, exp}, {15'h0000, high});
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    word16_type  m;
    word16_type  c;
    void'($urandom(83389));
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    // every register comes up zero, a hole answers with an error
    for (int i = 0; i < 7; i++) begin
      axi_read(12'(i * 4), d, r);
      compare_word("reset value", 32'h0000_0000, d);
    end
    axi_read(12'h01c, d, r);
    compare_resp("unmapped read", `RESP_SLVERR, r);
    // both polarities against normal, zero, negative and above-modulus compares
    for (int k = 0; k < 8; k++) begin
      m = (k == 7) ? 16'h0001 : 16'(8 + $urandom % 100);
      case (k / 2)
        0: c = 16'(1 + $urandom % (m - 1));
        1: c = 16'h0000;
        2: c = 16'h8000 | 16'($urandom);
        default: c = m + 16'(1 + $urandom % 50);
      endcase
      prog(m, c, {1'b1, k[0], 1'b1});
      axi_read(`CMP_LOW_OFFSET, d, r);
      compare_word("compare low readback", {24'h000000, c[7:0]}, d);
      measure(m, expect_high(m, c, k[0]));
    end
    // a low clock enable freezes the counter; the first edge after lowering it already holds it
    clock_enable_in <= 1'b0;
    @(posedge clock_in);
    d = {16'h0000, counter};
    repeat (20) @(posedge clock_in);
    compare_word("frozen count", d, {16'h0000, counter});
    clock_enable_in <= 1'b1;
    // one byte alone must not change the period, the pair does
    axi_write(`MOD_LOW_OFFSET, 8'h60);
    measure(16'h0001, expect_high(16'h0001, c, 1'b1));
    axi_write(`MOD_HIGH_OFFSET, 8'h00);
    measure(16'h0060, expect_high(16'h0060, c, 1'b1));
    // leave center mode before the zero modulus goes in
    axi_write(`CTRL_OFFSET, 8'h04);
    axi_write(`MOD_HIGH_OFFSET, 8'h00);
    axi_write(`MOD_LOW_OFFSET, 8'h00);
    do @(posedge clock_in); while (counter !== 16'hffff);
    @(posedge clock_in);
    compare_word("free run wrap", 32'h0000_0000, {16'h0000, counter});
    tally_and_finish();
  end
endmodule
